// ===== logic/rsb_pkg.sv
// package: register map, field positions, reset values and timing counts for the reset/boot block
package rsb_pkg;
    // register indices (printed offsets are not all multiples of four, so byte address is index*4)
    localparam logic [7:0]  IDX_CHIP_CONTROL   = 8'h9F;
    localparam logic [7:0]  IDX_RESET_FLAGS    = 8'hA2;
    localparam logic [7:0]  IDX_WATCHDOG_CTRL  = 8'hAA;
    localparam logic [7:0]  IDX_BOOT_CONFIG    = 8'hB0;
    localparam logic [7:0]  IDX_GUARD_KEY      = 8'hB1;
    localparam logic [7:0]  IDX_IRQ_STATUS     = 8'hB2;
    localparam logic [7:0]  IDX_IRQ_MASK       = 8'hB3;
    localparam logic [7:0]  IDX_RESET_CMD      = 8'hB4;
    localparam int          ADDR_W             = 12;

    // chip_control fields
    localparam int          CC_SOFT_TRIG_BIT   = 7;
    localparam int          CC_BOOT_SEL_BIT    = 1;
    // reset_source_flags fields
    localparam int          RF_SOFT_BIT        = 7;
    localparam int          RF_PIN_BIT         = 6;
    localparam int          RF_FAULT_BIT       = 5;
    // watchdog_control field
    localparam int          WD_FLAG_BIT        = 3;
    // boot_config_byte fields
    localparam int          BC_BOOT_CFG_BIT    = 7;
    localparam int          BC_DEBUG_EN_BIT    = 4;

    localparam logic [7:0]  CHIP_CONTROL_RST   = 8'h00;
    localparam logic [7:0]  RESET_FLAGS_RST    = 8'h00;
    localparam logic [7:0]  WATCHDOG_CTRL_RST  = 8'h07;
    localparam logic [7:0]  BOOT_CONFIG_RST    = 8'hFF;
    localparam logic [7:0]  FLAG_MASK          = 8'hE0;

    // timed access: two key bytes in a row open a short write window
    localparam logic [7:0]  GUARD_KEY1         = 8'hAA;
    localparam logic [7:0]  GUARD_KEY2         = 8'h55;
    localparam int          GUARD_WINDOW       = 4;

    // irq status bits: one per reset source
    localparam int          IRQ_PIN            = 0;
    localparam int          IRQ_FAULT          = 1;
    localparam int          IRQ_WDOG           = 2;
    localparam int          IRQ_SOFT           = 3;
    localparam int          IRQ_W              = 4;

    // timing
    localparam int          CLK_MHZ            = 200;
    localparam int          PIN_LOW_CYCLES     = 24;
    localparam int          CLK_STABLE_NS      = 100;
    localparam int          CLK_STABLE_CYCLES  = (CLK_STABLE_NS * CLK_MHZ + 999) / 1000;
    localparam int          SOFT_HOLD_CYCLES   = 8;
    localparam int          CNT_W              = 8;
    localparam logic [15:0] BOOT_VECTOR        = 16'h0000;

    typedef enum logic [3:0] {
        RSB_RUN    = 4'b0001,
        RSB_WAKE   = 4'b0010,
        RSB_HOLD   = 4'b0100,
        RSB_SOFT   = 4'b1000
    } rsb_state_e;
endpackage

// ===== logic/rsb_pin_filter.sv
// pin synchronizer and low-time counter for the external reset pin
`timescale 1ns/10ps
module rsb_pin_filter #(
    parameter int MIN_LOW = rsb_pkg::PIN_LOW_CYCLES
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic arst_n,
    // pin side
    input  wire logic ext_reset_n_pin,
    // result
    output logic      pin_low_sync,
    output logic      pin_valid
);
    logic                      meta_q;
    logic                      sync_q;
    logic [rsb_pkg::CNT_W-1:0] cnt_q;
    logic [rsb_pkg::CNT_W-1:0] cnt_d;

    always_comb begin
        cnt_d = cnt_q;
        if (sync_q) begin
            cnt_d = '0;
        end else if (cnt_q != rsb_pkg::CNT_W'(MIN_LOW)) begin
            cnt_d = cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
            cnt_q  <= '0;
        end else begin
            meta_q <= ext_reset_n_pin;
            sync_q <= meta_q;
            cnt_q  <= cnt_d;
        end
    end

    assign pin_low_sync = ~sync_q;
    assign pin_valid    = (cnt_q == rsb_pkg::CNT_W'(MIN_LOW));
endmodule

// ===== logic/rsb_reset_boot.sv
// reset source sequencer, sticky source flags, boot select and apb register file
`timescale 1ns/10ps
module rsb_reset_boot #(
    parameter int MIN_LOW    = rsb_pkg::PIN_LOW_CYCLES,
    parameter int STABLE_CYC = rsb_pkg::CLK_STABLE_CYCLES,
    parameter int SOFT_CYC   = rsb_pkg::SOFT_HOLD_CYCLES
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // reset sources
    input  wire logic        ext_reset_n_pin,
    input  wire logic        fetch_over_flash,
    input  wire logic        fetch_fault_int_en,
    input  wire logic        on_chip_debugger,
    input  wire logic        watchdog_timeout,
    input  wire logic        power_down,
    // clock control
    output logic             clk_restart_req,
    // system outputs
    output logic             sys_reset,
    output logic             boot_from_loader,
    output logic [15:0]      boot_vector,
    output logic             irq
);
    ////////////////////////////////////////////////////////////////////////////
    logic       pin_low_sync;
    logic       pin_valid;

    rsb_pin_filter #(
        .MIN_LOW(MIN_LOW)
    ) u_pin (
        .clk            (clk),
        .arst_n         (arst_n),
        .ext_reset_n_pin(ext_reset_n_pin),
        .pin_low_sync   (pin_low_sync),
        .pin_valid      (pin_valid)
    );

    function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
        return a == {2'b00, idx, 2'b00};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // apb decode
    logic        acc;
    logic        wr;
    logic        rd;
    logic        lane0;
    logic [7:0]  wbyte;
    logic        mapped;

    assign acc    = psel & penable;
    assign wr     = acc & pwrite & pstrb[0];
    assign rd     = acc & ~pwrite;
    assign wbyte  = pwdata[7:0];
    assign lane0  = pstrb[0];
    assign mapped = hit(paddr, rsb_pkg::IDX_CHIP_CONTROL) | hit(paddr, rsb_pkg::IDX_RESET_FLAGS)
                  | hit(paddr, rsb_pkg::IDX_WATCHDOG_CTRL) | hit(paddr, rsb_pkg::IDX_BOOT_CONFIG)
                  | hit(paddr, rsb_pkg::IDX_GUARD_KEY) | hit(paddr, rsb_pkg::IDX_IRQ_STATUS)
                  | hit(paddr, rsb_pkg::IDX_IRQ_MASK);

    ////////////////////////////////////////////////////////////////////////////
    // registers
    localparam int IRQ_W_L = rsb_pkg::IRQ_W;
    rsb_pkg::rsb_state_e     state_q, state_d;
    logic [rsb_pkg::CNT_W-1:0] tmr_q, tmr_d;
    logic [7:0]  flags_q, flags_d;
    logic [7:0]  wdc_q, wdc_d;
    logic [7:0]  cfg_q, cfg_d;
    logic        bsel_q, bsel_d;
    logic        trig_q, trig_d;
    logic [1:0]  key_q, key_d;
    logic [2:0]  win_q, win_d;
    logic [IRQ_W_L-1:0] ist_q, ist_d;
    logic [IRQ_W_L-1:0] imask_q, imask_d;
    logic        soft_kind_q, soft_kind_d;
    logic        rst_q, rst_d;
    logic        wake_q, wake_d;
    logic [31:0] prdata_q, prdata_d;
    logic        pready_q, pready_d;
    logic        perr_q, perr_d;

    // events raised this cycle
    logic        fault_ev;
    logic        fault_rst;
    logic        guard_open;
    logic        soft_req;
    logic        in_reset;

    assign guard_open = (win_q != 3'h0);
    assign fault_ev   = fetch_over_flash & ~fetch_fault_int_en & (state_q == rsb_pkg::RSB_RUN);
    // debug with debug enable cleared: flag only, no reset
    assign fault_rst  = fault_ev & ~(on_chip_debugger & ~cfg_q[rsb_pkg::BC_DEBUG_EN_BIT]);
    assign soft_req   = wr & pready_q & hit(paddr, rsb_pkg::IDX_CHIP_CONTROL) & guard_open
                      & wbyte[rsb_pkg::CC_SOFT_TRIG_BIT] & (state_q == rsb_pkg::RSB_RUN);
    assign in_reset   = (state_q != rsb_pkg::RSB_RUN);

    always_comb begin
        state_d     = state_q;
        tmr_d       = tmr_q;
        flags_d     = flags_q;
        wdc_d       = wdc_q;
        cfg_d       = cfg_q;
        bsel_d      = bsel_q;
        trig_d      = trig_q;
        key_d       = key_q;
        win_d       = guard_open ? win_q - 3'h1 : win_q;
        ist_d       = ist_q;
        imask_d     = imask_q;
        soft_kind_d = soft_kind_q;
        prdata_d    = 32'h0000_0000;
        pready_d    = 1'b0;
        perr_d      = 1'b0;

        // writes land at the completing edge; clear first, hardware sets later win
        if (wr && pready_q && state_q == rsb_pkg::RSB_RUN) begin
            if (hit(paddr, rsb_pkg::IDX_RESET_FLAGS)) begin
                flags_d = (flags_q & ~rsb_pkg::FLAG_MASK) | (wbyte & rsb_pkg::FLAG_MASK);
            end
            if (hit(paddr, rsb_pkg::IDX_WATCHDOG_CTRL) && guard_open) begin
                wdc_d = wbyte;
            end
            if (hit(paddr, rsb_pkg::IDX_CHIP_CONTROL) && guard_open) begin
                bsel_d = wbyte[rsb_pkg::CC_BOOT_SEL_BIT];
            end
            if (hit(paddr, rsb_pkg::IDX_BOOT_CONFIG)) begin
                cfg_d = wbyte;
            end
            if (hit(paddr, rsb_pkg::IDX_IRQ_STATUS)) begin
                ist_d = ist_q & ~wbyte[IRQ_W_L-1:0];
            end
            if (hit(paddr, rsb_pkg::IDX_IRQ_MASK)) begin
                imask_d = wbyte[IRQ_W_L-1:0];
            end
            if (hit(paddr, rsb_pkg::IDX_GUARD_KEY)) begin
                key_d = 2'b00;
                if (wbyte == rsb_pkg::GUARD_KEY1) begin
                    key_d = 2'b01;
                end else if (wbyte == rsb_pkg::GUARD_KEY2 && key_q == 2'b01) begin
                    win_d = 3'(rsb_pkg::GUARD_WINDOW);
                end
            end
        end

        // apb answer one cycle after the access phase starts
        if (acc && !pready_q) begin
            pready_d = 1'b1;
            perr_d   = ~mapped | ~lane0 & pwrite;
            if (rd) begin
                if (hit(paddr, rsb_pkg::IDX_CHIP_CONTROL)) begin
                    prdata_d[7:0] = {1'b0, 5'b00000, bsel_q, 1'b0}; // trigger bit is write-only
                end else if (hit(paddr, rsb_pkg::IDX_RESET_FLAGS)) begin
                    prdata_d[7:0] = flags_q;
                end else if (hit(paddr, rsb_pkg::IDX_WATCHDOG_CTRL)) begin
                    prdata_d[7:0] = wdc_q;
                end else if (hit(paddr, rsb_pkg::IDX_BOOT_CONFIG)) begin
                    prdata_d[7:0] = cfg_q;
                end else if (hit(paddr, rsb_pkg::IDX_IRQ_STATUS)) begin
                    prdata_d[IRQ_W_L-1:0] = ist_q;
                end else if (hit(paddr, rsb_pkg::IDX_IRQ_MASK)) begin
                    prdata_d[IRQ_W_L-1:0] = imask_q;
                end
            end
        end

        // reset sequencer; pin has top priority
        case (state_q)
            rsb_pkg::RSB_RUN: begin
                if (power_down && pin_low_sync) begin
                    state_d = rsb_pkg::RSB_WAKE;
                    tmr_d   = '0;
                end else if (pin_valid) begin
                    state_d     = rsb_pkg::RSB_HOLD;
                    soft_kind_d = 1'b0;
                    flags_d[rsb_pkg::RF_PIN_BIT]   = 1'b1;
                    flags_d[rsb_pkg::RF_FAULT_BIT] = 1'b0;
                    ist_d[rsb_pkg::IRQ_PIN] = 1'b1;
                    bsel_d = ~cfg_q[rsb_pkg::BC_BOOT_CFG_BIT];
                end else if (watchdog_timeout) begin
                    state_d     = rsb_pkg::RSB_SOFT;
                    tmr_d       = '0;
                    soft_kind_d = 1'b0;
                    wdc_d[rsb_pkg::WD_FLAG_BIT] = 1'b1;
                    ist_d[rsb_pkg::IRQ_WDOG] = 1'b1;
                    bsel_d = ~cfg_q[rsb_pkg::BC_BOOT_CFG_BIT];
                end else if (fault_ev) begin
                    flags_d[rsb_pkg::RF_FAULT_BIT] = 1'b1;
                    ist_d[rsb_pkg::IRQ_FAULT] = 1'b1;
                    if (fault_rst) begin
                        state_d     = rsb_pkg::RSB_SOFT;
                        tmr_d       = '0;
                        soft_kind_d = 1'b0;
                        bsel_d = ~cfg_q[rsb_pkg::BC_BOOT_CFG_BIT];
                    end
                end else if (soft_req) begin
                    // the write completes on this edge, then reset: nothing later runs
                    state_d     = rsb_pkg::RSB_SOFT;
                    tmr_d       = '0;
                    trig_d      = 1'b1;
                    soft_kind_d = 1'b1;
                    flags_d[rsb_pkg::RF_SOFT_BIT] = 1'b1;
                    ist_d[rsb_pkg::IRQ_SOFT] = 1'b1;
                    bsel_d = bsel_q;
                end
            end
            rsb_pkg::RSB_WAKE: begin
                // clock restarted; wait for it to settle before entering reset
                if (tmr_q == rsb_pkg::CNT_W'(STABLE_CYC)) begin
                    state_d     = rsb_pkg::RSB_HOLD;
                    soft_kind_d = 1'b0;
                    flags_d[rsb_pkg::RF_PIN_BIT]   = 1'b1;
                    flags_d[rsb_pkg::RF_FAULT_BIT] = 1'b0;
                    ist_d[rsb_pkg::IRQ_PIN] = 1'b1;
                    bsel_d = ~cfg_q[rsb_pkg::BC_BOOT_CFG_BIT];
                end else begin
                    tmr_d = tmr_q + 1'b1;
                end
            end
            rsb_pkg::RSB_HOLD: begin
                if (!pin_low_sync) begin
                    state_d = rsb_pkg::RSB_RUN;
                end
            end
            rsb_pkg::RSB_SOFT: begin
                if (pin_valid) begin
                    state_d = rsb_pkg::RSB_HOLD;
                    trig_d  = 1'b0;
                    flags_d[rsb_pkg::RF_PIN_BIT]   = 1'b1;
                    flags_d[rsb_pkg::RF_FAULT_BIT] = 1'b0;
                    ist_d[rsb_pkg::IRQ_PIN] = 1'b1;
                    bsel_d = ~cfg_q[rsb_pkg::BC_BOOT_CFG_BIT];
                end else if (tmr_q == rsb_pkg::CNT_W'(SOFT_CYC)) begin
                    state_d = rsb_pkg::RSB_RUN;
                    trig_d  = 1'b0;
                end else begin
                    tmr_d = tmr_q + 1'b1;
                end
            end
            default: begin
                state_d = rsb_pkg::RSB_HOLD;
            end
        endcase
    end

    assign rst_d  = (state_d == rsb_pkg::RSB_HOLD) | (state_d == rsb_pkg::RSB_SOFT);
    assign wake_d = (state_d == rsb_pkg::RSB_WAKE);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q     <= rsb_pkg::RSB_HOLD;
            tmr_q       <= '0;
            flags_q     <= rsb_pkg::RESET_FLAGS_RST;
            wdc_q       <= rsb_pkg::WATCHDOG_CTRL_RST;
            cfg_q       <= rsb_pkg::BOOT_CONFIG_RST;
            bsel_q      <= ~rsb_pkg::BOOT_CONFIG_RST[rsb_pkg::BC_BOOT_CFG_BIT];
            trig_q      <= 1'b0;
            key_q       <= 2'b00;
            win_q       <= 3'h0;
            ist_q       <= '0;
            imask_q     <= '0;
            soft_kind_q <= 1'b0;
            rst_q       <= 1'b1;
            wake_q      <= 1'b0;
            prdata_q    <= 32'h0000_0000;
            pready_q    <= 1'b0;
            perr_q      <= 1'b0;
        end else begin
            state_q     <= state_d;
            tmr_q       <= tmr_d;
            flags_q     <= flags_d;
            wdc_q       <= wdc_d;
            cfg_q       <= cfg_d;
            bsel_q      <= bsel_d;
            trig_q      <= trig_d;
            key_q       <= key_d;
            win_q       <= win_d;
            ist_q       <= ist_d;
            imask_q     <= imask_d;
            soft_kind_q <= soft_kind_d;
            rst_q       <= rst_d;
            wake_q      <= wake_d;
            prdata_q    <= prdata_d;
            pready_q    <= pready_d;
            perr_q      <= perr_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    logic irq_q;
    logic ldr_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_q <= 1'b0;
            ldr_q <= ~rsb_pkg::BOOT_CONFIG_RST[rsb_pkg::BC_BOOT_CFG_BIT];
        end else begin
            irq_q <= |(ist_d & imask_d);
            ldr_q <= bsel_d;
        end
    end

    assign prdata           = prdata_q;
    assign pready           = pready_q;
    assign pslverr          = perr_q;
    assign sys_reset        = rst_q;
    assign clk_restart_req  = wake_q;
    assign boot_from_loader = ldr_q;
    assign boot_vector      = rsb_pkg::BOOT_VECTOR;
    assign irq              = irq_q;
    logic in_reset_unused;
    assign in_reset_unused  = in_reset;
endmodule

// ===== verification/rsb_reset_boot_properties.sv
// checker: port-level timing relations of the reset and boot block
`timescale 1ns/10ps
module rsb_reset_boot_chk #(
    parameter int MIN_LOW = 24
) (
    // clock and reset
    input wire logic        clk,
    input wire logic        arst_n,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic        pslverr,
    // sources and outputs
    input wire logic        ext_reset_n_pin,
    input wire logic        fetch_over_flash,
    input wire logic        fetch_fault_int_en,
    input wire logic        on_chip_debugger,
    input wire logic        watchdog_timeout,
    input wire logic        power_down,
    input wire logic        clk_restart_req,
    input wire logic        sys_reset,
    input wire logic [15:0] boot_vector
);
    logic [7:0] low_cnt_q;
    logic [7:0] low_cnt_d;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // power-down excluded: the clock wake wait adds an unknown delay
    always_comb begin
        low_cnt_d = low_cnt_q;
        if (ext_reset_n_pin || power_down)
            low_cnt_d = 8'h00;
        else if (low_cnt_q != 8'hFF)
            low_cnt_d = low_cnt_q + 8'h01;
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            low_cnt_q <= 8'h00;
        else
            low_cnt_q <= low_cnt_d;
    end
    a_apb_answer: assert property (psel && penable && !pready |=> pready)
        else $error("apb access not answered next cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_vector_zero: assert property (boot_vector == 16'h0000)
        else $error("boot vector not zero");
    a_pin_reset: assert property (int'(low_cnt_q) >= MIN_LOW + 6 |-> sys_reset)
        else $error("long pin low without internal reset");
    a_wdog_reset: assert property (watchdog_timeout && !sys_reset |-> ##[1:4] sys_reset)
        else $error("watchdog timeout did not reset");
    a_fault_reset: assert property (fetch_over_flash && !fetch_fault_int_en && !on_chip_debugger && !sys_reset
        |-> ##[1:4] sys_reset)
        else $error("fetch fault did not reset");
    a_clk_wake: assert property ($fell(ext_reset_n_pin) && power_down && !sys_reset
        |-> ##[1:4] clk_restart_req)
        else $error("no clock restart on pin in power-down");
    a_wait_stable: assert property ($rose(clk_restart_req) && !sys_reset |-> !sys_reset [*8])
        else $error("reset before clock stable");
endmodule

bind rsb_reset_boot rsb_reset_boot_chk #(.MIN_LOW(MIN_LOW)) chk_u (
    .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
    .ext_reset_n_pin(ext_reset_n_pin), .fetch_over_flash(fetch_over_flash),
    .fetch_fault_int_en(fetch_fault_int_en), .on_chip_debugger(on_chip_debugger),
    .watchdog_timeout(watchdog_timeout), .power_down(power_down), .clk_restart_req(clk_restart_req),
    .sys_reset(sys_reset), .boot_vector(boot_vector));

// ===== verification/rsb_board_model.sv
// board reset source: pulls the pin low for a commanded number of cycles
`timescale 1ns/10ps
module rsb_board_model (
    // clock and power-on
    input wire logic       clk,
    input wire logic       arst_n,
    // command
    input wire logic       go,
    input wire logic [7:0] hold,
    // pin
    output logic           ext_reset_n_pin
);
    logic [7:0] left_q;
    logic [7:0] left_d;
    always_comb begin
        left_d = left_q;
        if (go)
            left_d = hold;
        else if (left_q != 8'h00)
            left_d = left_q - 8'h01;
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            left_q <= 8'h00;
        else
            left_q <= left_d;
    end
    // pull-up on the board: released pin reads high
    assign ext_reset_n_pin = (left_q == 8'h00);
endmodule

// ===== verification/tb_top.sv
// testbench: registers, reset sources, boot select and interrupt of the reset block
`timescale 1ns/10ps
module tb_top;
    logic        clk, arst_n, psel, penable, pwrite, fetch_over_flash, fetch_fault_int_en, er;
    logic        on_chip_debugger, watchdog_timeout, power_down, go, pin, clk_restart_req;
    logic        sys_reset, boot_from_loader, irq, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb;
    logic [15:0] boot_vector;
    logic [7:0]  hold;
    logic [44:0] row [0:5];
    int          err_count, total_checks, cyc, n;

    rsb_board_model brd_u (.clk(clk), .arst_n(arst_n), .go(go), .hold(hold), .ext_reset_n_pin(pin));
    rsb_reset_boot dut_u (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_reset_n_pin(pin), .fetch_over_flash(fetch_over_flash),
        .fetch_fault_int_en(fetch_fault_int_en), .on_chip_debugger(on_chip_debugger),
        .watchdog_timeout(watchdog_timeout), .power_down(power_down), .clk_restart_req(clk_restart_req),
        .sys_reset(sys_reset), .boot_from_loader(boot_from_loader), .boot_vector(boot_vector), .irq(irq));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////
    task close_out;
        if (err_count == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // called right after an edge; last=0 keeps psel for a back-to-back setup
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic last);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rd = prdata;
        er = pslverr;
        penable <= 1'b0;
        if (last)
            psel <= 1'b0;
    endtask
    task wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        apb(1'b1, a, {24'h000000, d}, 1'b1);
    endtask
    task rdc(input logic [11:0] a, input logic [7:0] exp);
        @(posedge clk);
        apb(1'b0, a, 32'h0, 1'b1);
        chk({24'h000000, rd[7:0]}, {24'h000000, exp});
    endtask
    // {pin go, watchdog timeout, fetch fault} for one cycle
    task kick(input logic [2:0] v, input logic [7:0] h);
        @(posedge clk);
        hold <= h;
        {go, watchdog_timeout, fetch_over_flash} <= v;
        @(posedge clk);
        {go, watchdog_timeout, fetch_over_flash} <= 3'b000;
    endtask
    task see_rst;
        int k;
        k = 0;
        while (sys_reset !== 1'b1 && k < 300) begin
            @(posedge clk);
            k++;
        end
        chk(sys_reset, 1'b1);
        k = 0;
        while (sys_reset !== 1'b0 && k < 300) begin
            @(posedge clk);
            k++;
        end
        chk(sys_reset, 1'b0);
    endtask
    task quiet;
        n = 0;
        repeat (40) begin
            @(posedge clk);
            if (sys_reset !== 1'b0)
                n++;
        end
    endtask
    ////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        cyc++;
        if (cyc == 8000) begin
            err_count++;
            close_out();
        end
    end

    initial begin
        {arst_n, psel, penable, pwrite, fetch_over_flash, fetch_fault_int_en, go} = 7'h00;
        {on_chip_debugger, watchdog_timeout, power_down} = 3'h0;
        {paddr, pwdata, hold} = 52'h0;
        pstrb = 4'hF;
        row = '{{12'h27C, 32'h00, 1'b0}, {12'h288, 32'h00, 1'b0}, {12'h2A8, 32'h07, 1'b0},
                {12'h2C0, 32'hFF, 1'b0}, {12'h2C8, 32'h00, 1'b0}, {12'h3F0, 32'h00, 1'b1}};
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        see_rst();
        chk(boot_from_loader, 1'b0);
        foreach (row[i]) begin
            @(posedge clk);
            apb(1'b0, row[i][44:33], 32'h0, 1'b1);
            chk(er, row[i][0]);
            if (!row[i][0])
                chk({24'h000000, rd[7:0]}, row[i][8:1]);
        end
        @(posedge clk);
        pstrb <= 4'hE;
        apb(1'b1, 12'h2CC, 32'h1, 1'b1);
        chk(er, 1'b1);
        pstrb <= 4'hF;
        kick(3'b100, 8'd30);
        see_rst();
        rdc(12'h288, 8'h40);
        rdc(12'h2C8, 8'h01);
        chk(irq, 1'b0);
        wr(12'h2CC, 8'h01);
        repeat (2) @(posedge clk);
        chk(irq, 1'b1);
        wr(12'h2C8, 8'h01);
        repeat (2) @(posedge clk);
        chk(irq, 1'b0);
        kick(3'b100, 8'd10);
        quiet();
        chk(n, 0);
        kick(3'b001, 8'd0);
        see_rst();
        rdc(12'h288, 8'h60);
        fetch_fault_int_en <= 1'b1;
        kick(3'b001, 8'd0);
        quiet();
        chk(n, 0);
        fetch_fault_int_en <= 1'b0;
        wr(12'h288, 8'h00);
        rdc(12'h288, 8'h00);
        wr(12'h2C0, 8'hEF);
        on_chip_debugger <= 1'b1;
        kick(3'b001, 8'd0);
        quiet();
        chk(n, 0);
        rdc(12'h288, 8'h20);
        on_chip_debugger <= 1'b0;
        wr(12'h2C0, 8'h7F);
        kick(3'b100, 8'd30);
        see_rst();
        rdc(12'h288, 8'h40);
        chk(boot_from_loader, 1'b1);
        rdc(12'h27C, 8'h02);
        wr(12'h2C0, 8'hFF);
        @(posedge clk);
        apb(1'b1, 12'h2C4, 32'hAA, 1'b0);
        apb(1'b1, 12'h2C4, 32'h55, 1'b0);
        apb(1'b1, 12'h27C, 32'h82, 1'b1);
        see_rst();
        chk(boot_from_loader, 1'b1);
        rdc(12'h288, 8'hC0);
        rdc(12'h27C, 8'h02);
        kick(3'b010, 8'd0);
        see_rst();
        rdc(12'h2A8, 8'h0F);
        rdc(12'h288, 8'hC0);
        chk(boot_from_loader, 1'b0);
        power_down <= 1'b1;
        kick(3'b100, 8'd90);
        n = 0;
        while (clk_restart_req !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        chk(clk_restart_req, 1'b1);
        see_rst();
        power_down <= 1'b0;
        // mid-run power-on style reset: flags back to their power-on values
        arst_n <= 1'b0;
        @(posedge clk);
        arst_n <= 1'b1;
        see_rst();
        rdc(12'h288, 8'h00);
        rdc(12'h2A8, 8'h07);
        chk(boot_from_loader, 1'b0);
        close_out();
    end
endmodule
